/* File: rtl/lcdk_defines.svh */
`ifndef LCDK_DEFINES_SVH
`define LCDK_DEFINES_SVH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define LCDK_ADDR_W       8
`define LCDK_ADDR_DISP    8'h41
`define LCDK_ADDR_KEY     8'h43
`define LCDK_PAYLOAD_W    81
`define LCDK_CHUNK_W      76
`define LCDK_CHUNK4_W     75
`define LCDK_IDX_LSB      76
`define LCDK_DUTY_BIT     78
`define LCDK_SLEEP_LSB    79
`define LCDK_CHUNKS3      3
`define LCDK_CHUNKS4      4
`define LCDK_KEY_W        30
`define LCDK_READ_W       31

// ----------------------------------------------------------------
// Pins
// ----------------------------------------------------------------
`define LCDK_GPO_W        8
`define LCDK_SEG_W        65
`define LCDK_COM_W        3
`define LCDK_ROWS         6
`define LCDK_COLS         5
`define LCDK_SCAN_RST     6'h20
`define LCDK_SLEEP_KS6    2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LCDK_OSC_DIV      100
`define LCDK_SCAN_WIN_T   615
`define LCDK_SCAN_RETRY_T 1230
`define LCDK_SCAN_STEP_T  51
`define LCDK_CL_HALF      6
`define LCDK_CLK_MHZ      100
`define LCDK_DISP_MS      30

// ----------------------------------------------------------------
// Controller register map (word index) and bits
// ----------------------------------------------------------------
`define LCDK_REG_CTRL     4'h0
`define LCDK_REG_STAT     4'h1
`define LCDK_REG_MASK     4'h2
`define LCDK_REG_KEY      4'h3
`define LCDK_REG_DISP0    4'h4
`define LCDK_DISP_WORDS   10
`define LCDK_CTRL_GO      0
`define LCDK_CTRL_DUTY4   1
`define LCDK_CTRL_SLEEP   2
`define LCDK_CTRL_IRQMODE 4
`define LCDK_CTRL_RESREL  5
`define LCDK_CTRL_RDNOW   6
`define LCDK_EV_W         4
`define LCDK_EV_DONE      0
`define LCDK_EV_KEY       1
`define LCDK_EV_INVALID   2
`define LCDK_EV_LATE      3

`endif

/* File: rtl/lcdk_pkg.sv */
package lcdk_pkg;
	typedef enum logic [2:0] {
		D_IDLE  = 3'b001,
		D_SCAN  = 3'b010,
		D_READY = 3'b100
	} lcdk_dstate_t;

	typedef enum logic [2:0] {
		H_IDLE  = 3'b001,
		H_FRAME = 3'b010,
		H_GAP   = 3'b100
	} lcdk_hstate_t;
endpackage

/* File: rtl/lcdk_if.sv */
`timescale 1ns/1ps
interface lcdk_if;
	logic ce;
	logic cl;
	logic di;
	logic reset_input_n;
	logic do_o;
	logic do_oe_n;
	logic do_line;

	// Pull-up: released line reads high
	assign do_line = do_oe_n | do_o;

	modport dev (
		input  ce,
		input  cl,
		input  di,
		input  reset_input_n,
		output do_o,
		output do_oe_n
	);
	modport host (
		output ce,
		output cl,
		output di,
		output reset_input_n,
		input  do_line
	);
endinterface

/* File: rtl/lcdk_scan_timer.sv */
`timescale 1ns/1ps
`include "lcdk_defines.svh"
module lcdk_scan_timer
	import lcdk_pkg::*;
#(
	parameter int OSC_DIV = `LCDK_OSC_DIV
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	input  wire logic       start,
	input  wire logic       stop,
	output logic      [2:0] row,
	output logic            pass,
	output logic            step_end,
	output logic            win_end
);
	localparam int OW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
	localparam int TW = $clog2(`LCDK_SCAN_WIN_T);
	localparam int SW = $clog2(`LCDK_SCAN_STEP_T);
	localparam int STEPS = 2 * `LCDK_ROWS;

	typedef struct packed {
		logic          run;
		logic [OW-1:0] osc;
		logic [TW-1:0] tcnt;
		logic [SW-1:0] scnt;
		logic    [3:0] step;
	} lcdk_tmr_t;

	lcdk_tmr_t q;
	lcdk_tmr_t d;
	logic      tick;

	assign tick = q.run && (q.osc == OW'(OSC_DIV - 1));
	assign pass = (q.step >= 4'(`LCDK_ROWS));
	assign row  = pass ? 3'(q.step - 4'(`LCDK_ROWS)) : q.step[2:0];

	always_comb begin
		d        = q;
		step_end = 1'b0;
		win_end  = 1'b0;
		if (q.run) begin
			d.osc = tick ? '0 : q.osc + 1'b1;
		end
		if (tick) begin
			d.tcnt = q.tcnt + 1'b1;
			if (q.step < 4'(STEPS)) begin
				if (q.scnt == SW'(`LCDK_SCAN_STEP_T - 1)) begin
					d.scnt   = '0;
					d.step   = q.step + 1'b1;
					step_end = 1'b1;
				end else begin
					d.scnt = q.scnt + 1'b1;
				end
			end
			// Window length fixed in oscillator periods
			if (q.tcnt == TW'(`LCDK_SCAN_WIN_T - 1)) begin
				win_end = 1'b1;
				d.run   = 1'b0;
			end
		end
		if (start) begin
			d     = '0;
			d.run = 1'b1;
		end
		if (stop) begin
			d = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end
endmodule // lcdk_scan_timer

/* File: rtl/lcdk_device.sv */
`timescale 1ns/1ps
`include "lcdk_defines.svh"
module lcdk_device
	import lcdk_pkg::*;
#(
	parameter int OSC_DIV = `LCDK_OSC_DIV
) (
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	input  wire logic                   clk_en,
	lcdk_if.dev                         link,
	input  wire logic [`LCDK_COLS-1:0]  key_in,
	output logic      [`LCDK_GPO_W-1:0] shared_seg_gpo_pins,
	output logic      [`LCDK_SEG_W-1:0] seg_out,
	output logic      [`LCDK_COM_W-1:0] com_out,
	output logic                        shared_common4_seg_pin,
	output logic                        shared_common4_is_com,
	output logic                  [1:0] shared_scan_seg_pins,
	output logic                  [2:0] scan_out_three_to_five,
	output logic                        scan_out_six,
	output logic                        display_on
);
	localparam int CH = `LCDK_CHUNKS4;
	localparam int CW = `LCDK_CHUNK_W;
	localparam int PW = `LCDK_PAYLOAD_W;
	localparam int AW = `LCDK_ADDR_W;
	localparam int KW = `LCDK_KEY_W;
	localparam int RW = `LCDK_READ_W;
	localparam int NR = `LCDK_ROWS;
	localparam int NC = `LCDK_COLS;

	typedef struct packed {
		logic                  ce_m, ce_s, ce_p;
		logic                  cl_m, cl_s, cl_p;
		logic                  di_m, di_s;
		logic                  res_m, res_s;
		logic         [NC-1:0] ki_m, ki_s;
		logic                  por;
		logic         [CH-1:0] got;
		logic                  duty4, duty_seen;
		logic            [1:0] sleep;
		logic                  sleep_seen;
		logic         [AW-1:0] addr;
		logic         [PW-1:0] pl;
		logic            [6:0] bitcnt;
		logic                  reading;
		logic         [RW-1:0] rd_sh;
		logic [CH-1:0][CW-1:0] disp;
		lcdk_dstate_t          state;
		logic         [KW-1:0] kbuf, samp_a, samp_b;
		logic                  do_pull;
		logic   [`LCDK_GPO_W-1:0] gpo;
		logic   [`LCDK_SEG_W-1:0] seg;
		logic   [`LCDK_COM_W-1:0] com;
		logic                  com4, com4_is_com, disp_on;
		logic         [NR-1:0] scan;
	} lcdk_dev_t;

	localparam lcdk_dev_t ST_RST = '{
		por: 1'b1, com4_is_com: 1'b1, state: D_IDLE,
		scan: `LCDK_SCAN_RST, default: '0};

	lcdk_dev_t q;
	lcdk_dev_t d;
	logic          sys_rst;
	logic          cl_rise;
	logic          ce_rise;
	logic          ce_fall;
	logic [AW-1:0] addr_n;
	logic    [1:0] idx;
	logic [CH-1:0] got_n;
	logic [CH-1:0] need;
	logic [NR-1:0] rows;
	logic [CW-1:0] d0;
	logic          t_start;
	logic          t_stop;
	logic    [2:0] t_row;
	logic          t_pass;
	logic          t_step;
	logic          t_win;

	// ----------------------------------------------------------------
	// Scan window timing
	// ----------------------------------------------------------------
	lcdk_scan_timer #(
		.OSC_DIV (OSC_DIV)
	) u_timer (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.start    (t_start),
		.stop     (t_stop),
		.row      (t_row),
		.pass     (t_pass),
		.step_end (t_step),
		.win_end  (t_win)
	);

	assign sys_rst = q.por | ~q.res_s;
	assign cl_rise = q.cl_s & ~q.cl_p;
	assign ce_rise = q.ce_s & ~q.ce_p;
	assign ce_fall = ~q.ce_s & q.ce_p;
	assign addr_n  = {q.di_s, q.addr[AW-1:1]};
	// Start must beat stop on the cycle that enters the scan
	assign t_stop  = sys_rst | ((q.state != D_SCAN) & ~t_start);
	assign d0      = q.disp[0];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d       = q;
		t_start = 1'b0;
		idx     = q.pl[`LCDK_IDX_LSB +: 2];
		got_n   = q.got | (CH'(1) << idx);
		need    = q.pl[`LCDK_DUTY_BIT] ? CH'(4'hF) : CH'(4'h7);
		d.ce_m  = link.ce;
		d.ce_s  = q.ce_m;
		d.ce_p  = q.ce_s;
		d.cl_m  = link.cl;
		d.cl_s  = q.cl_m;
		d.cl_p  = q.cl_s;
		d.di_m  = link.di;
		d.di_s  = q.di_m;
		d.res_m = link.reset_input_n;
		d.res_s = q.res_m;
		d.ki_m  = key_in;
		d.ki_s  = q.ki_m;

		// Serial side keeps working in reset so the reset can end
		if (ce_rise) begin
			d.bitcnt  = '0;
			d.reading = 1'b0;
		end
		if (q.ce_s && cl_rise) begin
			if (q.bitcnt < 7'(AW)) begin
				d.addr = addr_n;
			end else if (q.addr == `LCDK_ADDR_DISP) begin
				d.pl = {q.di_s, q.pl[PW-1:1]};
			end
			if (q.reading) begin
				d.rd_sh = q.rd_sh >> 1;
			end
			if (q.bitcnt == 7'(AW - 1) && addr_n == `LCDK_ADDR_KEY) begin
				d.reading = 1'b1;
				d.rd_sh   = {q.sleep != 2'h0, q.kbuf};
			end
			if (q.bitcnt != 7'h7F) begin
				d.bitcnt = q.bitcnt + 1'b1;
			end
		end
		if (ce_fall) begin
			d.reading = 1'b0;
			if (q.addr == `LCDK_ADDR_DISP &&
				q.bitcnt == 7'(AW + PW)) begin
				d.disp[idx]  = q.pl[CW-1:0];
				d.got        = got_n;
				d.duty4      = q.pl[`LCDK_DUTY_BIT];
				d.duty_seen  = 1'b1;
				d.sleep      = q.pl[`LCDK_SLEEP_LSB +: 2];
				d.sleep_seen = 1'b1;
				// Power-on reset ends with the last frame
				if ((got_n & need) == need) begin
					d.por = 1'b0;
				end
			end
		end

		// ----------------------------------------------------------------
		// Key scan
		// ----------------------------------------------------------------
		if (sys_rst) begin
			d.kbuf  = '0;
			d.state = D_IDLE;
		end else begin
			case (q.state)
				D_IDLE: begin
					if (|q.ki_s && !q.reading) begin
						d.state = D_SCAN;
						t_start = 1'b1;
					end
				end
				D_SCAN: begin
					if (t_step && !t_pass) begin
						d.samp_a[t_row * NC +: NC] = q.ki_s;
					end
					if (t_step && t_pass) begin
						d.samp_b[t_row * NC +: NC] = q.ki_s;
					end
					// Disagreement costs a second window
					if (t_win) begin
						if (q.samp_a == q.samp_b) begin
							d.kbuf  = q.samp_b;
							d.state = D_READY;
						end else begin
							t_start = 1'b1;
						end
					end
				end
				D_READY: begin
					if (ce_fall && q.reading) begin
						d.state = D_IDLE;
					end
				end
				default: begin
					d.state = D_IDLE;
				end
			endcase
		end

		// ----------------------------------------------------------------
		// Pins, registered
		// ----------------------------------------------------------------
		if (q.state == D_SCAN) begin
			rows = NR'(1) << t_row;
		end else if (q.sleep == `LCDK_SLEEP_KS6) begin
			rows = `LCDK_SCAN_RST;
		end else begin
			rows = '1;
		end
		// Three to five undefined before sleep bits; driven anyway
		d.scan = sys_rst ? `LCDK_SCAN_RST : rows;
		d.gpo  = sys_rst ? '0 : d0[`LCDK_GPO_W-1:0];
		d.seg  = sys_rst ? '0 : d0[`LCDK_GPO_W +: `LCDK_SEG_W];
		d.com  = sys_rst ? '0 : '1;
		d.disp_on     = ~sys_rst;
		d.com4_is_com = ~q.duty_seen | q.duty4;
		d.com4 = sys_rst ? 1'b0 :
			(d.com4_is_com | d0[`LCDK_GPO_W + `LCDK_SEG_W]);
		// Released whenever reset holds, read or not
		d.do_pull = ~sys_rst &
			(((q.state == D_READY) & ~q.ce_s) |
			(q.reading & ~q.rd_sh[0]));
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			q <= ST_RST;
		end else if (clk_en) begin
			q <= d;
		end
	end

	assign link.do_o              = 1'b0;
	assign link.do_oe_n           = ~q.do_pull;
	assign shared_seg_gpo_pins    = q.gpo;
	assign seg_out                = q.seg;
	assign com_out                = q.com;
	assign shared_common4_seg_pin = q.com4;
	assign shared_common4_is_com  = q.com4_is_com;
	assign shared_scan_seg_pins   = q.scan[1:0];
	assign scan_out_three_to_five = q.scan[4:2];
	assign scan_out_six           = q.scan[5];
	assign display_on             = q.disp_on;
endmodule // lcdk_device

/* File: rtl/lcdk_host.sv */
`timescale 1ns/1ps
`include "lcdk_defines.svh"
module lcdk_host
	import lcdk_pkg::*;
#(
	parameter int OSC_DIV  = `LCDK_OSC_DIV,
	parameter int CL_HALF  = `LCDK_CL_HALF,
	parameter int HOLD_CYC = `LCDK_SCAN_RETRY_T * OSC_DIV + 1,
	parameter int POLL_CYC = HOLD_CYC +
		(`LCDK_ADDR_W + `LCDK_READ_W) * 2 * CL_HALF,
	parameter int LATE_CYC = `LCDK_DISP_MS * 1000 * `LCDK_CLK_MHZ
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	lcdk_if.host             link,
	input  wire logic  [3:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq
);
	localparam int TW = `LCDK_ADDR_W + `LCDK_PAYLOAD_W;
	localparam int RW = `LCDK_READ_W;
	localparam int EW = `LCDK_EV_W;
	localparam int NW = `LCDK_DISP_WORDS;

	typedef struct packed {
		logic                 res_out, duty4, irq_mode, go, rdnow;
		logic           [1:0] sleep;
		logic        [EW-1:0] stat, mask;
		logic        [RW-1:0] key, rx;
		logic [NW-1:0] [31:0] disp;
		logic          [31:0] rdata;
		logic                 do_m, do_s;
		lcdk_hstate_t         state;
		logic                 is_read, kinv, chain;
		logic           [1:0] chunk;
		logic          [15:0] div;
		logic                 cl, ce, di;
		logic           [6:0] bitcnt;
		logic        [TW-1:0] sh;
		logic          [31:0] wait_c, late_c;
	} lcdk_host_t;

	lcdk_host_t    q;
	lcdk_host_t    d;
	logic [EW-1:0] ev;
	logic          half;
	logic    [6:0] nbits;
	logic    [6:0] cw;
	logic  [NW*32-1:0] flat;
	logic [`LCDK_CHUNK_W-1:0] chunk_bits;
	logic    [1:0] last;

	assign half  = (q.div == 16'(CL_HALF - 1));
	assign nbits = q.is_read ? 7'(`LCDK_ADDR_W + RW) : 7'(TW);
	assign cw    = q.duty4 ? 7'(`LCDK_CHUNK4_W) : 7'(`LCDK_CHUNK_W);
	assign last  = q.duty4 ? 2'(`LCDK_CHUNKS4 - 1) : 2'(`LCDK_CHUNKS3 - 1);
	assign flat  = q.disp;

	always_comb begin
		d          = q;
		ev         = '0;
		d.do_m     = link.do_line;
		d.do_s     = q.do_m;
		d.late_c   = q.late_c + 32'(q.state != H_IDLE && !q.is_read);
		chunk_bits = `LCDK_CHUNK_W'(flat >>
			(32'(q.chain ? q.chunk : 2'h0) * 32'(cw)));
		if (q.duty4) begin
			chunk_bits[`LCDK_CHUNK_W-1] = 1'b0;
		end

		// ----------------------------------------------------------------
		// Frame engine
		// ----------------------------------------------------------------
		case (q.state)
			H_IDLE: begin
				if (q.wait_c != '0) begin
					d.wait_c = q.wait_c - 1'b1;
				end
				if (q.go) begin
					d.go      = 1'b0;
					d.chain   = 1'b0;
					// Only a software start rewinds to the first chunk
					if (!q.chain) begin
						d.chunk  = '0;
						d.late_c = '0;
					end
					d.is_read = 1'b0;
					d.state   = H_FRAME;
				// Look at data-out only with CE low
				end else if (q.rdnow ||
					(q.wait_c == '0 && q.res_out && !q.do_s)) begin
					d.rdnow   = 1'b0;
					d.kinv    = q.do_s;
					d.is_read = 1'b1;
					d.state   = H_FRAME;
				end else if (q.wait_c == '0 && !q.irq_mode) begin
					d.wait_c = 32'(POLL_CYC);
				end
				if (d.state == H_FRAME) begin
					d.sh = d.is_read ? TW'(`LCDK_ADDR_KEY) :
						{q.sleep, q.duty4, d.chunk, chunk_bits,
						`LCDK_ADDR_DISP};
					d.ce     = 1'b1;
					d.di     = d.sh[0];
					d.cl     = 1'b0;
					d.div    = '0;
					d.bitcnt = '0;
				end
			end
			H_FRAME: begin
				d.div = half ? '0 : q.div + 1'b1;
				if (half) begin
					d.cl = ~q.cl;
					if (!q.cl && q.is_read &&
						q.bitcnt >= 7'(`LCDK_ADDR_W)) begin
						d.rx = {q.do_s, q.rx[RW-1:1]};
					end
					if (q.cl) begin
						d.bitcnt = q.bitcnt + 1'b1;
						d.sh     = q.sh >> 1;
						d.di     = d.sh[0];
						if (d.bitcnt == nbits) begin
							d.ce    = 1'b0;
							d.di    = 1'b0;
							d.state = H_GAP;
						end
					end
				end
			end
			H_GAP: begin
				d.div = half ? '0 : q.div + 1'b1;
				if (half) begin
					d.state = H_IDLE;
					if (q.is_read) begin
						// Data read with data-out high is discarded
						if (q.kinv) begin
							ev[`LCDK_EV_INVALID] = 1'b1;
						end else begin
							d.key             = q.rx;
							ev[`LCDK_EV_KEY] = 1'b1;
						end
						d.wait_c = q.irq_mode ? 32'(HOLD_CYC) :
							32'(POLL_CYC);
					end else if (q.chunk != last) begin
						// Next frame follows at once
						d.chunk = q.chunk + 1'b1;
						d.go    = 1'b1;
						d.chain = 1'b1;
					end else begin
						ev[`LCDK_EV_DONE] = 1'b1;
						ev[`LCDK_EV_LATE] = (q.late_c > 32'(LATE_CYC));
					end
				end
			end
			default: begin
				d.state = H_IDLE;
			end
		endcase
		if (q.state == H_GAP && half && !q.is_read && q.chunk != last) begin
			d.late_c = q.late_c;
		end

		// ----------------------------------------------------------------
		// Register port
		// ----------------------------------------------------------------
		d.stat = q.stat | ev;
		if (reg_wr) begin
			case (reg_addr)
				`LCDK_REG_CTRL: begin
					d.go       = reg_wdata[`LCDK_CTRL_GO] | d.go;
					d.duty4    = reg_wdata[`LCDK_CTRL_DUTY4];
					d.sleep    = reg_wdata[`LCDK_CTRL_SLEEP +: 2];
					d.irq_mode = reg_wdata[`LCDK_CTRL_IRQMODE];
					d.res_out  = reg_wdata[`LCDK_CTRL_RESREL];
					d.rdnow    = reg_wdata[`LCDK_CTRL_RDNOW];
				end
				// Set wins over a write-one clear
				`LCDK_REG_STAT: d.stat = (q.stat & ~reg_wdata[EW-1:0]) | ev;
				`LCDK_REG_MASK: d.mask = reg_wdata[EW-1:0];
				default: begin
					if (reg_addr >= `LCDK_REG_DISP0 &&
						reg_addr < 4'(`LCDK_REG_DISP0 + NW)) begin
						d.disp[reg_addr - `LCDK_REG_DISP0] = reg_wdata;
					end
				end
			endcase
		end
		d.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				`LCDK_REG_CTRL: d.rdata = 32'({q.rdnow, q.res_out,
					q.irq_mode, q.sleep, q.duty4, q.go});
				`LCDK_REG_STAT: d.rdata = 32'(q.stat);
				`LCDK_REG_MASK: d.rdata = 32'(q.mask);
				`LCDK_REG_KEY:  d.rdata = 32'(q.key);
				default: begin
					if (reg_addr >= `LCDK_REG_DISP0 &&
						reg_addr < 4'(`LCDK_REG_DISP0 + NW)) begin
						d.rdata = q.disp[reg_addr - `LCDK_REG_DISP0];
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			q       <= '0;
			q.state <= H_IDLE;
			q.do_m  <= 1'b1;
			q.do_s  <= 1'b1;
		end else if (clk_en) begin
			q <= d;
		end
	end

	assign link.ce            = q.ce;
	assign link.cl            = q.cl;
	assign link.di            = q.di;
	assign link.reset_input_n = q.res_out;
	assign reg_rdata          = q.rdata;
	assign irq                = |(q.stat & q.mask);
endmodule // lcdk_host

/* File: bench/lcdk_props.sv */
`timescale 1ns/1ps
`include "lcdk_defines.svh"
module lcdk_props
	import lcdk_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic cl,
	input wire logic di,
	input wire logic reset_input_n,
	input wire logic do_o,
	input wire logic do_oe_n
);
	typedef struct packed {
		logic       cl;
		logic [6:0] cnt;
		logic [7:0] adr;
	} lcdk_frm_t;

	lcdk_frm_t s_q;
	lcdk_frm_t s_d;
	logic      fr_ok;

	// ----
	// Frame tracking
	// ----
	// Address arrives LSB first on the first eight clock rises
	always_comb begin
		s_d = s_q;
		s_d.cl = cl;
		if (!ce)
			s_d.cnt = 7'h00;
		else if (cl && !s_q.cl) begin
			s_d.cnt = s_q.cnt + 7'h01;
			if (s_q.cnt < 7'h08)
				s_d.adr = {di, s_q.adr[7:1]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// 89 clock rises for display data, 39 for a key read
	assign fr_ok = (s_q.adr == `LCDK_ADDR_DISP && s_q.cnt == 7'h59) ||
		(s_q.adr == `LCDK_ADDR_KEY && s_q.cnt == 7'h27);

	// ----
	// Properties
	// ----
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// Half period of 5 matches the CL_HALF the bench sets
	sequence s_cl_half;
		cl [*5] ##1 !cl;
	endsequence
	sequence s_gap;
		(!ce && !cl) [*5];
	endsequence

	AST_DO_NEVER_HIGH: assert property (do_o == 1'b0)
		else $error("data-out driven high");
	AST_RESET_IDLE: assert property ($rose(nrst) |-> !reset_input_n && !ce)
		else $error("link not idle after reset");
	AST_DEV_RESET_REL: assert property (!reset_input_n [*4] |=> do_oe_n)
		else $error("data-out pulled in device reset");
	AST_CL_IN_FRAME: assert property ($rose(cl) |-> ce && $past(ce))
		else $error("link clock outside frame");
	AST_CL_HALF: assert property ($rose(cl) |-> s_cl_half)
		else $error("link clock high time wrong");
	AST_DI_STABLE: assert property (cl && $past(cl) |-> $stable(di))
		else $error("data changed while clock high");
	AST_FRAME_GAP: assert property ($fell(ce) |-> s_gap)
		else $error("frame gap too short");
	AST_FRAME_SHAPE: assert property ($fell(ce) |-> fr_ok)
		else $error("frame address or length wrong");
endmodule // lcdk_props

/* File: bench/lcdk_bench.sv */
`timescale 1ns/1ps
`include "lcdk_defines.svh"
module lcdk_bench
	import lcdk_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  ra = 4'h0;
	logic [31:0] wd = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        clk_en = 1'b1;
	logic [31:0] rdat;
	logic        irq;
	logic [29:0] keys = 30'h0;
	logic [4:0]  kin;
	logic [5:0]  rows;
	logic [7:0]  gpo;
	logic [64:0] seg;
	logic [2:0]  com;
	logic        c4;
	logic        c4com;
	logic [1:0]  ks12;
	logic [2:0]  ks35;
	logic        ks6;
	logic        don;
	int          err_total = 0;
	int          n_compared = 0;

	lcdk_if link ();

	always #5 ref_clk = ~ref_clk;

	// Key matrix: a pressed key joins its row drive to its column
	assign rows = {ks6, ks35, ks12};
	always_comb begin
		kin = 5'h00;
		for (int i = 0; i < 30; i++)
			if (keys[i] && rows[i / 5])
				kin[i % 5] = 1'b1;
	end

	lcdk_device #(.OSC_DIV(2)) i_lcdk_device (
		.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .link(link),
		.key_in(kin), .shared_seg_gpo_pins(gpo), .seg_out(seg),
		.com_out(com), .shared_common4_seg_pin(c4),
		.shared_common4_is_com(c4com), .shared_scan_seg_pins(ks12),
		.scan_out_three_to_five(ks35), .scan_out_six(ks6),
		.display_on(don)
	);
	// Short late limit: a display load over 5000 cycles raises the late flag
	lcdk_host #(.OSC_DIV(2), .CL_HALF(5), .LATE_CYC(5000)) i_lcdk_host (
		.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .link(link),
		.reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdat), .irq(irq)
	);
	lcdk_props i_lcdk_props (
		.ref_clk(ref_clk), .nrst(nrst), .ce(link.ce), .cl(link.cl),
		.di(link.di), .reset_input_n(link.reset_input_n),
		.do_o(link.do_o), .do_oe_n(link.do_oe_n)
	);

	// ----
	// Shared tasks
	// ----
	task automatic chk(input string nm, input logic [64:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask

	task automatic wait_ev(input int b, input int lim);
		logic [31:0] s;
		s = 32'h0;
		for (int i = 0; i < lim && s[b] !== 1'b1; i++)
			rd_reg(`LCDK_REG_STAT, s);
		chk("status event", s[b], 1);
	endtask

	task automatic do_reset();
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
	endtask

	task automatic t_load(input logic [31:0] ctrl);
		for (int w = 0; w < `LCDK_DISP_WORDS; w++)
			wr_reg(4'(`LCDK_REG_DISP0 + w), 32'hA5C3_0F96 ^ 32'(w));
		wr_reg(`LCDK_REG_STAT, 32'hF);
		wr_reg(`LCDK_REG_CTRL, ctrl | 32'h1);
		wait_ev(`LCDK_EV_DONE, 4000);
		repeat (8) @(negedge ref_clk);
	endtask

	task automatic final_report();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		logic [31:0] v;
		@(negedge ref_clk);
		chk("shared outputs", gpo, 0);
		chk("shared scan 1-2", ks12, 0);
		chk("segments", seg, 0);
		chk("commons", com, 0);
		chk("scan 6", ks6, 1);
		chk("fourth common", {c4com, c4}, 2'h2);
		chk("data-out", link.do_line, 1);
		rd_reg(`LCDK_REG_KEY, v);
		chk("key buffer", v, 0);
		rd_reg(4'hE, v);
		chk("unmapped", v, 0);
		$display("test reset done");
	endtask

	task automatic t_duty3();
		t_load(32'h0);
		chk("held by reset pin", don, 0);
		chk("fourth as segment", c4com, 0);
		wr_reg(`LCDK_REG_CTRL, 32'h20);
		repeat (8) @(negedge ref_clk);
		chk("display on", don, 1);
		$display("test duty 3 done");
	endtask

	task automatic t_key(input int k, input logic [31:0] mode);
		logic [31:0] v;
		int          t;
		wr_reg(`LCDK_REG_CTRL, mode);
		wr_reg(`LCDK_REG_MASK, 32'h2);
		wr_reg(`LCDK_REG_STAT, 32'hF);
		keys <= 30'h1 << k;
		t = 0;
		while (link.do_line !== 1'b0 && t < 3000) begin
			@(negedge ref_clk);
			t++;
		end
		// Sync and pin stages add a few cycles to 615T
		chk("scan time", t >= 1230 && t <= 1260, 1);
		chk("frame idle at key", link.ce, 0);
		wait_ev(`LCDK_EV_KEY, 2000);
		rd_reg(`LCDK_REG_KEY, v);
		chk("key data", v, 32'h1 << k);
		chk("irq raised", irq, 1);
		wr_reg(`LCDK_REG_MASK, 32'h0);
		keys <= 30'h0;
		repeat (2) @(negedge ref_clk);
		chk("irq masked", irq, 0);
		// Rescan after release reports an empty buffer; read it out
		// so the next scenario starts with data-out released
		wr_reg(`LCDK_REG_STAT, 32'hF);
		wait_ev(`LCDK_EV_KEY, 3000);
		rd_reg(`LCDK_REG_KEY, v);
		chk("key released", v, 0);
		wr_reg(`LCDK_REG_STAT, 32'hF);
		wr_reg(`LCDK_REG_MASK, 32'h2);
		repeat (2) @(negedge ref_clk);
		chk("irq cleared", irq, 0);
		$display("test key %0d done", k);
	endtask

	task automatic t_inval();
		wr_reg(`LCDK_REG_STAT, 32'hF);
		wr_reg(`LCDK_REG_CTRL, 32'h60);
		wait_ev(`LCDK_EV_INVALID, 400);
		$display("test invalid read done");
	endtask

	task automatic t_devrst();
		logic [31:0] v;
		int          lows;
		wr_reg(`LCDK_REG_CTRL, 32'h0);
		keys <= 30'h80;
		wr_reg(`LCDK_REG_STAT, 32'hF);
		wr_reg(`LCDK_REG_CTRL, 32'h40);
		lows = 0;
		repeat (2000) begin
			@(negedge ref_clk);
			lows += (link.do_line !== 1'b1);
		end
		chk("data-out held", lows, 0);
		rd_reg(`LCDK_REG_STAT, v);
		chk("read in reset", v[2], 1);
		chk("display off", don, 0);
		chk("scan 6 high", ks6, 1);
		chk("segments low", seg, 0);
		// Frozen clock enable: the release write must be lost
		clk_en <= 1'b0;
		wr_reg(`LCDK_REG_CTRL, 32'h20);
		repeat (8) @(negedge ref_clk);
		chk("frozen", don, 0);
		clk_en <= 1'b1;
		wr_reg(`LCDK_REG_CTRL, 32'h20);
		keys <= 30'h0;
		repeat (8) @(negedge ref_clk);
		chk("display back", don, 1);
		$display("test device reset done");
	endtask

	task automatic t_duty4();
		logic [31:0] v;
		t_load(32'h2A);
		chk("display after four", don, 1);
		chk("fourth common", c4com, 1);
		chk("scan 3-5 asleep", ks35, 0);
		chk("scan 6 asleep", ks6, 1);
		rd_reg(`LCDK_REG_STAT, v);
		chk("no late flag", v[3], 0);
		$display("test duty 4 done");
	endtask

	initial begin
		do_reset();
		t_reset();
		t_duty3();
		t_key(0, 32'h20);
		t_key(29, 32'h30);
		t_inval();
		t_devrst();
		do_reset();
		t_duty4();
		final_report();
	end

	// Run needs about 21000 cycles
	initial begin
		#600000;
		err_total++;
		final_report();
	end
endmodule // lcdk_bench
